// File: core/phm_phase_measure_unit.sv
`timescale 1ns/1ns
// How it works
// - enable bit runs repeated 8 us measurements
// - 1 MHz counter 0..7 readable in control
// - all results update at 7 to 0 wrap
// - all results come from one period
// - last sample or period mean, mean default
// - phase is rounded angle, 256 steps per turn
// - unit phasor times 63, or rounded raw parts
// - quality is inverse phase deviation, 255 best
// - signed frequency offset, needs 1 MHz rate
// - center frequency changes optionally wait for boundary
// - real and imaginary results are signed
module phm_phase_measure_unit #(
	parameter int IQ_W    = 12,
	parameter int CNT_W   = 10,
	parameter int QF_GAIN = 4
) (
	// clock and reset
	input  wire logic                          ref_clk,
	input  wire logic                          rst,
	// receiver digital frontend samples
	input  wire logic                          iq_valid,
	input  wire logic signed [IQ_W-1:0]        i_data,
	input  wire logic signed [IQ_W-1:0]        q_data,
	// register access port
	input  wire logic [phm_pkg::ADDR_W-1:0]    reg_addr,
	input  wire logic                          reg_wr,
	input  wire logic [7:0]                    reg_wdata,
	output logic [7:0]                         reg_rdata,
	// channel center frequency change
	input  wire logic                          cf_change_req,
	output logic                               cf_change_apply
);
	import phm_pkg::*;
	localparam int SW = IQ_W + CNT_W;
	localparam int DW = 8 + CNT_W;
	localparam int CW = IQ_W + FRAC + 1;
	localparam logic signed [CW-1:0] NSTART = CW'(NORM_START);

	logic [7:0]             ctrl_q, ctrl_d, rdata_q, rdata_d;
	logic                   cf_pend_q, cf_pend_d, cf_apply_q, cf_apply_d;
	logic [PRE_W-1:0]       pre_q, pre_d;
	logic [2:0]             sub_q, sub_d;
	logic                   run_q, run_d, en, live, wrap, clr;
	logic signed [SW-1:0]   sum_i_q, sum_i_d, sum_q_q, sum_q_d;
	logic [CNT_W-1:0]       ns_q, ns_d, nd_q, nd_d, ndd_q, ndd_d;
	logic signed [IQ_W-1:0] last_i_q, last_i_d, last_q_q, last_q_d;
	logic signed [IQ_W-1:0] mean_i, mean_q, xs_q, xs_d, ys_q, ys_d;
	logic [7:0]             prev_a_q, prev_a_d, a8, absdd;
	logic signed [7:0]      prev_d_q, prev_d_d, dph, dd;
	logic                   have1_q, have1_d, have2_q, have2_d;
	logic signed [DW-1:0]   sd_q, sd_d;
	logic [DW-1:0]          sa_q, sa_d;
	logic signed [DW:0]     fq;
	logic [DW+3:0]          dev;
	logic [7:0]             freq8, qual8, raw_i8, raw_q8;
	logic                   trk_busy, trk_done, trk_start;
	logic [ANGLE_W-1:0]     trk_z, c_z;
	logic                   c_start, c_rot, c_done;
	logic signed [CW-1:0]   c_x, c_y, c_xin, c_yin;
	phm_calc_t              calc_q, calc_d;
	logic                   sel_q, sel_d;
	logic [7:0]             ph_p_q, ph_p_d, qf_p_q, qf_p_d, re_p_q, re_p_d, im_p_q, im_p_d;
	logic [7:0]             ph_q, ph_d, qf_q, qf_d, re_q, re_d, im_q, im_d;

	// angle to 256 steps per turn, rounded
	function automatic logic [7:0] rnd_ang(input logic [ANGLE_W-1:0] z);
		logic [ANGLE_W-1:0] t;
		t = z + ANGLE_W'(1 << (ANGLE_W - 9));
		return t[ANGLE_W-1:ANGLE_W-8];
	endfunction

	// signed sample rounded to 8 bits, saturated
	function automatic logic [7:0] round8(input logic signed [IQ_W-1:0] v);
		logic signed [IQ_W:0] t;
		t = {v[IQ_W-1], v} + (IQ_W+1)'(1 << (IQ_W - 9));
		t = t >>> (IQ_W - 8);
		return (t > 127) ? 8'h7f : t[7:0];
	endfunction

	// rotated phasor back to integer, clamped to the scale
	function automatic logic [7:0] norm8(input logic signed [CW-1:0] v);
		logic signed [CW-1:0] t;
		t = (v + CW'(1 << (FRAC - 1))) >>> FRAC;
		if (t > NORM_SCALE)
			return 8'(NORM_SCALE);
		if (t < -NORM_SCALE)
			return 8'(-NORM_SCALE);
		return t[7:0];
	endfunction

	assign en = ctrl_q[BIT_EN];
	assign live = en & run_q;
	assign wrap = live && pre_q == TICK_LAST && sub_q == SUB_LAST;
	assign clr = wrap | ~live;

	// control register, read mux, center frequency alignment
	always_comb begin
		ctrl_d = ctrl_q;
		if (reg_wr && reg_addr == OFS_CONTROL)
			ctrl_d = (reg_wdata & CONTROL_WMASK) | (ctrl_q & ~CONTROL_WMASK);
		unique case (reg_addr)
			OFS_CONTROL: rdata_d = {ctrl_q[7:5], sub_q, ctrl_q[1:0]};
			OFS_PHASE:   rdata_d = ph_q;
			OFS_QUALITY: rdata_d = qf_q;
			OFS_REAL:    rdata_d = re_q;
			OFS_IMAG:    rdata_d = im_q;
			default:     rdata_d = 8'h00;
		endcase
		cf_pend_d = cf_pend_q | cf_change_req;
		cf_apply_d = cf_pend_d && (!ctrl_q[BIT_CF_ALIGN] || !en || wrap);
		if (cf_apply_d)
			cf_pend_d = 1'b0;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= CONTROL_RESET;
			rdata_q <= 8'h00;
			cf_pend_q <= 1'b0;
			cf_apply_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			rdata_q <= rdata_d;
			cf_pend_q <= cf_pend_d;
			cf_apply_q <= cf_apply_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign cf_change_apply = cf_apply_q;

	// 1 MHz prescaler and sub-period counter
	always_comb begin
		pre_d = pre_q + 1'b1;
		sub_d = sub_q;
		run_d = run_q;
		if (!en) begin
			pre_d = '0;
			sub_d = SUB_LAST;
			run_d = 1'b0;
		end else if (!run_q) begin
			pre_d = '0;
			sub_d = 3'h0;
			run_d = 1'b1;
		end else if (pre_q == TICK_LAST) begin
			pre_d = '0;
			sub_d = sub_q + 3'h1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pre_q <= '0;
			sub_q <= SUB_LAST;
			run_q <= 1'b0;
		end else begin
			pre_q <= pre_d;
			sub_q <= sub_d;
			run_q <= run_d;
		end
	end

	// per-sample phase tracker for drift and deviation
	phm_cordic #(.W(CW)) u_track (
		.ref_clk (ref_clk),
		.rst     (rst),
		.start   (trk_start),
		.rotate  (1'b0),
		.x_in    ({i_data[IQ_W-1], i_data, 4'h0}),
		.y_in    ({q_data[IQ_W-1], q_data, 4'h0}),
		.z_in    ('0),
		.busy    (trk_busy),
		.done    (trk_done),
		.x_out   (),
		.y_out   (),
		.z_out   (trk_z)
	);
	assign trk_start = live & iq_valid & ~trk_busy;

	// period accumulators; a sample in the wrap cycle opens the next period
	always_comb begin
		sum_i_d = clr ? '0 : sum_i_q;
		sum_q_d = clr ? '0 : sum_q_q;
		ns_d = clr ? '0 : ns_q;
		sd_d = clr ? '0 : sd_q;
		nd_d = clr ? '0 : nd_q;
		sa_d = clr ? '0 : sa_q;
		ndd_d = clr ? '0 : ndd_q;
		last_i_d = last_i_q;
		last_q_d = last_q_q;
		prev_a_d = prev_a_q;
		prev_d_d = prev_d_q;
		have1_d = have1_q & en;
		have2_d = have2_q & en;
		a8 = rnd_ang(trk_z);
		dph = a8 - prev_a_q;
		dd = dph - prev_d_q;
		absdd = dd[7] ? 8'(-dd) : dd;
		if (live && iq_valid) begin
			sum_i_d = sum_i_d + SW'(i_data);
			sum_q_d = sum_q_d + SW'(q_data);
			if (ns_d != '1)
				ns_d = ns_d + 1'b1;
			last_i_d = i_data;
			last_q_d = q_data;
		end
		if (trk_done && live) begin
			if (have1_q) begin
				sd_d = sd_d + DW'(dph);
				nd_d = nd_d + 1'b1;
				prev_d_d = dph;
				have2_d = 1'b1;
				if (have2_q) begin
					sa_d = sa_d + DW'(absdd);
					ndd_d = ndd_d + 1'b1;
				end
			end
			prev_a_d = a8;
			have1_d = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sum_i_q <= '0;
			sum_q_q <= '0;
			ns_q <= '0;
			sd_q <= '0;
			nd_q <= '0;
			sa_q <= '0;
			ndd_q <= '0;
			last_i_q <= '0;
			last_q_q <= '0;
			prev_a_q <= 8'h00;
			prev_d_q <= 8'h00;
			have1_q <= 1'b0;
			have2_q <= 1'b0;
		end else begin
			sum_i_q <= sum_i_d;
			sum_q_q <= sum_q_d;
			ns_q <= ns_d;
			sd_q <= sd_d;
			nd_q <= nd_d;
			sa_q <= sa_d;
			ndd_q <= ndd_d;
			last_i_q <= last_i_d;
			last_q_q <= last_q_d;
			prev_a_q <= prev_a_d;
			prev_d_q <= prev_d_d;
			have1_q <= have1_d;
			have2_q <= have2_d;
		end
	end

	// period figures from the accumulators
	always_comb begin
		mean_i = (ns_q == '0) ? last_i_q : IQ_W'(sum_i_q / $signed({1'b0, ns_q}));
		mean_q = (ns_q == '0) ? last_q_q : IQ_W'(sum_q_q / $signed({1'b0, ns_q}));
		fq = (nd_q == '0) ? (DW+1)'(0) : $signed({sd_q, 1'b0}) / $signed({1'b0, nd_q});
		freq8 = (fq > 127) ? 8'h7f : (fq < -128) ? 8'h80 : fq[7:0];
		dev = (ndd_q == '0) ? '0 : ((DW+4)'(sa_q) * (DW+4)'(QF_GAIN)) / (DW+4)'(ndd_q);
		qual8 = (dev >= (DW+4)'(QF_BEST)) ? 8'h00 : QF_BEST - dev[7:0];
		if (ndd_q == '0)
			qual8 = 8'h00;
		raw_i8 = round8(xs_q);
		raw_q8 = round8(ys_q);
	end

	// shared vectoring and rotation engine
	phm_cordic #(.W(CW)) u_calc (
		.ref_clk (ref_clk),
		.rst     (rst),
		.start   (c_start),
		.rotate  (c_rot),
		.x_in    (c_xin),
		.y_in    (c_yin),
		.z_in    ({ph_p_d, 4'h0}),
		.busy    (),
		.done    (c_done),
		.x_out   (c_x),
		.y_out   (c_y),
		.z_out   (c_z)
	);
	assign c_xin = c_rot ? NSTART : {xs_d[IQ_W-1], xs_d, 4'h0};
	assign c_yin = c_rot ? '0 : {ys_d[IQ_W-1], ys_d, 4'h0};

	// snapshot at wrap, then phase, then components
	always_comb begin
		calc_d = calc_q;
		xs_d = xs_q;
		ys_d = ys_q;
		sel_d = sel_q;
		ph_p_d = ph_p_q;
		qf_p_d = qf_p_q;
		re_p_d = re_p_q;
		im_p_d = im_p_q;
		c_start = 1'b0;
		c_rot = 1'b0;
		if (wrap) begin
			xs_d = ctrl_q[BIT_IQ_MEAN] ? mean_i : last_i_q;
			ys_d = ctrl_q[BIT_IQ_MEAN] ? mean_q : last_q_q;
			sel_d = ctrl_q[BIT_IQ_SEL];
			qf_p_d = ctrl_q[BIT_FREQ_ERR] ? freq8 : qual8;
			c_start = 1'b1;
			calc_d = CALC_VEC;
		end else begin
			unique case (calc_q)
				CALC_IDLE: ;
				CALC_VEC: if (c_done) begin
					ph_p_d = rnd_ang(c_z);
					if (sel_q) begin
						re_p_d = raw_i8;
						im_p_d = raw_q8;
						calc_d = CALC_IDLE;
					end else begin
						c_start = 1'b1;
						c_rot = 1'b1;
						calc_d = CALC_ROT;
					end
				end
				CALC_ROT: if (c_done) begin
					re_p_d = norm8(c_x);
					im_p_d = norm8(c_y);
					calc_d = CALC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			calc_q <= CALC_IDLE;
			xs_q <= '0;
			ys_q <= '0;
			sel_q <= 1'b0;
			ph_p_q <= RESULT_RESET;
			qf_p_q <= RESULT_RESET;
			re_p_q <= RESULT_RESET;
			im_p_q <= RESULT_RESET;
		end else begin
			calc_q <= calc_d;
			xs_q <= xs_d;
			ys_q <= ys_d;
			sel_q <= sel_d;
			ph_p_q <= ph_p_d;
			qf_p_q <= qf_p_d;
			re_p_q <= re_p_d;
			im_p_q <= im_p_d;
		end
	end

	// published results, all at once on the wrap
	always_comb begin
		ph_d = wrap ? ph_p_q : ph_q;
		qf_d = wrap ? qf_p_q : qf_q;
		re_d = wrap ? re_p_q : re_q;
		im_d = wrap ? im_p_q : im_q;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ph_q <= RESULT_RESET;
			qf_q <= RESULT_RESET;
			re_q <= RESULT_RESET;
			im_q <= RESULT_RESET;
		end else begin
			ph_q <= ph_d;
			qf_q <= qf_d;
			re_q <= re_d;
			im_q <= im_d;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_off_idle: assert property (
		!en |=> sub_q == SUB_LAST && !wrap)
		else $error("sub counter moves while disabled");
	a_sub_step: assert property (
		(live && pre_q == TICK_LAST) |=> sub_q == $past(sub_q) + 3'h1)
		else $error("sub counter did not step");
	a_sub_hold: assert property (
		(live && $past(live) && $changed(sub_q)) |-> ##1 $stable(sub_q) [*8])
		else $error("sub counter stepped too soon");
	a_update_wrap: assert property (
		($changed(ph_q) || $changed(qf_q) || $changed(re_q) || $changed(im_q)) |-> $past(wrap))
		else $error("result changed outside wrap");
	a_group_sync: assert property (
		wrap |=> ph_q == $past(ph_p_q) && qf_q == $past(qf_p_q) && re_q == $past(re_p_q)
			&& im_q == $past(im_p_q))
		else $error("results not published together");
	a_sample_pick: assert property (
		(wrap && !ctrl_q[BIT_IQ_MEAN]) |=> xs_q == $past(last_i_q) && ys_q == $past(last_q_q))
		else $error("sampled mode did not take last sample");
	a_calc_bound: assert property (
		wrap |=> ##[1:40] calc_q == CALC_IDLE)
		else $error("phase calculation did not finish");
	a_norm_range: assert property (
		(calc_q == CALC_ROT && c_done) |=> $signed(re_p_q) <= NORM_SCALE
			&& $signed(re_p_q) >= -NORM_SCALE && $signed(im_p_q) <= NORM_SCALE)
		else $error("normalized component out of range");
	a_quality_pick: assert property (
		(wrap && !ctrl_q[BIT_FREQ_ERR]) |=> qf_p_q == $past(qual8))
		else $error("quality figure not taken");
	a_freq_pick: assert property (
		(wrap && ctrl_q[BIT_FREQ_ERR]) |=> qf_p_q == $past(freq8))
		else $error("frequency estimate not taken");
	a_cf_now: assert property (
		(cf_change_req && !ctrl_q[BIT_CF_ALIGN]) |=> cf_change_apply)
		else $error("center change not applied at once");
	a_cf_defer: assert property (
		(cf_change_req && ctrl_q[BIT_CF_ALIGN] && en && !wrap && !cf_pend_q) |=> !cf_change_apply)
		else $error("aligned center change applied early");
	a_raw_parts: assert property (
		(calc_q == CALC_VEC && c_done && sel_q) |=> re_p_q == $past(raw_i8))
		else $error("raw real part wrong");
	a_hold_off: assert property (
		(!en && !$past(en)) |=> $stable(ph_q) && $stable(re_q) && $stable(qf_q))
		else $error("results changed while disabled");
endmodule

// File: core/phm_pkg.sv
package phm_pkg;
	// clock and measurement timing
	localparam int CLK_PERIOD_NS  = 10;
	localparam int SUB_PERIOD_NS  = 1000;
	localparam int MEAS_PERIOD_US = 8;
	localparam int TICK_CYCLES    = (SUB_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SUB_STEPS      = MEAS_PERIOD_US * 1000 / SUB_PERIOD_NS;
	localparam int PRE_W          = $clog2(TICK_CYCLES);
	localparam logic [PRE_W-1:0] TICK_LAST = PRE_W'(TICK_CYCLES - 1);
	localparam logic [2:0] SUB_LAST       = 3'(SUB_STEPS - 1);
	// register offsets
	localparam int ADDR_W = 3;
	localparam logic [ADDR_W-1:0] OFS_CONTROL = 3'h0;
	localparam logic [ADDR_W-1:0] OFS_PHASE   = 3'h1;
	localparam logic [ADDR_W-1:0] OFS_QUALITY = 3'h2;
	localparam logic [ADDR_W-1:0] OFS_REAL    = 3'h3;
	localparam logic [ADDR_W-1:0] OFS_IMAG    = 3'h4;
	// control field positions, reset values
	localparam int BIT_EN       = 0;
	localparam int BIT_IQ_MEAN  = 1;
	localparam int SYNC_LSB     = 2;
	localparam int BIT_FREQ_ERR = 5;
	localparam int BIT_IQ_SEL   = 6;
	localparam int BIT_CF_ALIGN = 7;
	localparam logic [7:0] CONTROL_RESET = 8'h1e;
	localparam logic [7:0] CONTROL_WMASK = 8'he3;
	localparam logic [7:0] RESULT_RESET  = 8'h00;
	localparam logic [7:0] QF_BEST       = 8'hff;
	// arithmetic
	localparam int NORM_SCALE  = 63;
	localparam int FRAC        = 4;
	localparam int NORM_START  = 612;
	localparam int ANGLE_W     = 12;
	localparam int CORDIC_ITER = 10;
	localparam logic [ANGLE_W-1:0] HALF_TURN = 12'h800;
	// result calculation sequence
	typedef enum logic [1:0] {
		CALC_IDLE,
		CALC_VEC,
		CALC_ROT
	} phm_calc_t;
endpackage

// File: core/phm_cordic.sv
`timescale 1ns/1ns
module phm_cordic #(
	parameter int W = 17
) (
	// clock and reset
	input  wire logic                          ref_clk,
	input  wire logic                          rst,
	// request
	input  wire logic                          start,
	input  wire logic                          rotate,
	input  wire logic signed [W-1:0]           x_in,
	input  wire logic signed [W-1:0]           y_in,
	input  wire logic [phm_pkg::ANGLE_W-1:0]   z_in,
	// answer
	output logic                               busy,
	output logic                               done,
	output logic signed [W-1:0]                x_out,
	output logic signed [W-1:0]                y_out,
	output logic [phm_pkg::ANGLE_W-1:0]        z_out
);
	import phm_pkg::*;
	localparam int IW   = W + 2;
	localparam int IT_W = $clog2(CORDIC_ITER + 1);
	logic signed [IW-1:0] x_q, x_d, y_q, y_d, xs, ys, xi, yi;
	logic [ANGLE_W-1:0]   z_q, z_d;
	logic [IT_W-1:0]      it_q, it_d;
	logic                 busy_q, busy_d, done_q, done_d, rot_q, rot_d, cw;

	// arctangent of 2^-i, 4096 steps per turn
	function automatic logic [ANGLE_W-1:0] atan_f(input logic [IT_W-1:0] i);
		case (i)
			4'h0: atan_f = 12'h200;
			4'h1: atan_f = 12'h12e;
			4'h2: atan_f = 12'h0a0;
			4'h3: atan_f = 12'h051;
			4'h4: atan_f = 12'h029;
			4'h5: atan_f = 12'h014;
			4'h6: atan_f = 12'h00a;
			4'h7: atan_f = 12'h005;
			4'h8: atan_f = 12'h003;
			4'h9: atan_f = 12'h001;
			default: atan_f = 12'h000;
		endcase
	endfunction

	// one micro-rotation per cycle after an optional half-turn pre-rotation
	always_comb begin
		x_d = x_q;
		y_d = y_q;
		z_d = z_q;
		it_d = it_q;
		busy_d = busy_q;
		rot_d = rot_q;
		done_d = 1'b0;
		xi = {{2{x_in[W-1]}}, x_in};
		yi = {{2{y_in[W-1]}}, y_in};
		xs = x_q >>> it_q;
		ys = y_q >>> it_q;
		cw = rot_q ? z_q[ANGLE_W-1] : ~y_q[IW-1];
		if (start) begin
			busy_d = 1'b1;
			it_d = '0;
			rot_d = rotate;
			if (rotate ? (z_in[ANGLE_W-1] ^ z_in[ANGLE_W-2]) : xi[IW-1]) begin
				x_d = -xi;
				y_d = -yi;
				z_d = rotate ? z_in + HALF_TURN : HALF_TURN;
			end else begin
				x_d = xi;
				y_d = yi;
				z_d = rotate ? z_in : '0;
			end
		end else if (busy_q) begin
			if (cw) begin
				x_d = x_q + ys;
				y_d = y_q - xs;
				z_d = z_q + atan_f(it_q);
			end else begin
				x_d = x_q - ys;
				y_d = y_q + xs;
				z_d = z_q - atan_f(it_q);
			end
			it_d = it_q + 1'b1;
			if (it_q == IT_W'(CORDIC_ITER - 1)) begin
				busy_d = 1'b0;
				done_d = 1'b1;
			end
		end
	end

	// iteration state
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			x_q <= '0;
			y_q <= '0;
			z_q <= '0;
			it_q <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			rot_q <= 1'b0;
		end else begin
			x_q <= x_d;
			y_q <= y_d;
			z_q <= z_d;
			it_q <= it_d;
			busy_q <= busy_d;
			done_q <= done_d;
			rot_q <= rot_d;
		end
	end

	assign busy = busy_q;
	assign done = done_q;
	assign x_out = x_q[W-1:0];
	assign y_out = y_q[W-1:0];
	assign z_out = z_q;
endmodule

// File: tb/phm_frontend_model.sv
`timescale 1ns/1ns
module phm_frontend_model (
	// clock and reset
	input  wire logic               ref_clk,
	input  wire logic               rst,
	// phasor pattern selection
	input  wire logic               run,
	input  wire logic               alt,
	input  wire logic [2:0]         base,
	input  wire logic [2:0]         step,
	// sample stream
	output logic                    iq_valid,
	output logic signed [11:0]      i_data,
	output logic signed [11:0]      q_data
);
	logic [6:0] cnt_q;
	logic [2:0] k_q;
	logic [2:0] idx;

	// cosine of a 45 degree step angle, magnitude 1024
	function automatic logic [11:0] cosv(input logic [2:0] a);
		case (a)
			3'h0: cosv = 12'h400;
			3'h1, 3'h7: cosv = 12'h2d4;
			3'h3, 3'h5: cosv = 12'hd2c;
			3'h4: cosv = 12'hc00;
			default: cosv = 12'h000;
		endcase
	endfunction

	// constant, alternating or rotating pattern
	always_comb idx = base + (alt ? {1'b0, k_q[0], 1'b0} : 3'(k_q * step));

	// one sample per 100 cycles; data lines toggle between strobes
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 7'h00;
			k_q <= 3'h0;
			iq_valid <= 1'b0;
			i_data <= 12'h000;
			q_data <= 12'h000;
		end else begin
			cnt_q <= (!run || cnt_q == 7'h63) ? 7'h00 : cnt_q + 7'h01;
			iq_valid <= run && cnt_q == 7'h31;
			if (run && cnt_q == 7'h31) begin
				i_data <= cosv(idx);
				q_data <= cosv(idx - 3'h2);
				k_q <= k_q + 3'h1;
			end else begin
				i_data <= ~i_data;
				q_data <= ~q_data;
				if (!run)
					k_q <= 3'h0;
			end
		end
	end
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ns
module testbench;
	import phm_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic iq_valid;
	logic signed [11:0] i_data;
	logic signed [11:0] q_data;
	logic [2:0] reg_addr = 3'h0;
	logic reg_wr = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic cf_change_req = 1'b0;
	logic cf_change_apply;
	logic run = 1'b0;
	logic alt = 1'b0;
	logic [2:0] base = 3'h0;
	logic [2:0] step = 3'h0;
	logic [7:0] raw_i [4] = '{8'h40, 8'h00, 8'hc0, 8'h00};
	logic [7:0] raw_q [4] = '{8'h00, 8'h40, 8'h00, 8'hc0};
	logic [7:0] nrm_i [4] = '{8'h3f, 8'h00, 8'hc1, 8'h00};
	logic [7:0] nrm_q [4] = '{8'h00, 8'h3f, 8'h00, 8'hc1};
	int n_fail = 0;
	int checks = 0;

	always #5 ref_clk = ~ref_clk;

	phm_phase_measure_unit DUT (.ref_clk(ref_clk), .rst(rst), .iq_valid(iq_valid),
		.i_data(i_data), .q_data(q_data), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cf_change_req(cf_change_req),
		.cf_change_apply(cf_change_apply));

	phm_frontend_model frontend (.ref_clk(ref_clk), .rst(rst), .run(run), .alt(alt),
		.base(base), .step(step), .iq_valid(iq_valid), .i_data(i_data), .q_data(q_data));

	// verdict and end of run
	task automatic results;
		if (n_fail == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// compare within a signed tolerance
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input int tol);
		logic signed [7:0] d;
		d = seen - exp;
		checks++;
		if ((seen !== exp) && (tol == 0 || $isunknown(seen) || d > tol || d < -tol)) begin
			n_fail++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// register port, entered and left at a falling edge
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge ref_clk);
		reg_wr = 1'b0;
		@(negedge ref_clk);
	endtask

	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		reg_addr = a;
		@(negedge ref_clk);
		d = reg_rdata;
	endtask

	task automatic chk_reg(input logic [2:0] a, input logic [7:0] exp, input int tol);
		logic [7:0] d;
		rd(a, d);
		check(d, exp, tol);
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	// pulse a frequency change and count cycles to its apply pulse
	task automatic cf_req(output int n);
		cf_change_req = 1'b1;
		@(negedge ref_clk);
		cf_change_req = 1'b0;
		n = 0;
		while (cf_change_apply !== 1'b1 && n < 1000) begin
			@(negedge ref_clk);
			n++;
		end
	endtask

	task automatic t_reset;
		chk_reg(OFS_CONTROL, CONTROL_RESET, 0);
		chk_reg(OFS_PHASE, 8'h00, 0);
		chk_reg(OFS_REAL, 8'h00, 0);
		chk_reg(OFS_IMAG, 8'h00, 0);
		chk_reg(3'h5, 8'h00, 0);
		wr(OFS_PHASE, 8'h55);
		chk_reg(OFS_PHASE, 8'h00, 0);
		wr(OFS_CONTROL, 8'he2);
		chk_reg(OFS_CONTROL, 8'hfe, 0);
		wr(OFS_CONTROL, 8'h00);
		chk_reg(OFS_CONTROL, 8'h1c, 0);
	endtask

	task automatic t_cf_now;
		int n;
		wr(OFS_CONTROL, 8'h00);
		cf_req(n);
		check(8'(n > 1), 8'h00, 0);
		wr(OFS_CONTROL, 8'h80);
		cf_req(n);
		check(8'(n > 1), 8'h00, 0);
	endtask

	task automatic t_const;
		for (int b = 0; b < 4; b++) begin
			base = 3'(2 * b);
			run = 1'b1;
			// the period holding the pattern change is published two wraps later
			wr(OFS_CONTROL, 8'h63);
			wait_cyc(2450);
			chk_reg(OFS_PHASE, 8'(64 * b), 1);
			chk_reg(OFS_QUALITY, 8'h00, 2);
			chk_reg(OFS_REAL, raw_i[b], 1);
			chk_reg(OFS_IMAG, raw_q[b], 1);
			wr(OFS_CONTROL, 8'h03);
			wait_cyc(1700);
			chk_reg(OFS_QUALITY, 8'hfb, 4);
			chk_reg(OFS_REAL, nrm_i[b], 1);
			chk_reg(OFS_IMAG, nrm_q[b], 1);
		end
	endtask

	task automatic t_avg;
		alt = 1'b1;
		base = 3'h0;
		wr(OFS_CONTROL, 8'h43);
		wait_cyc(2450);
		chk_reg(OFS_PHASE, 8'h20, 1);
		chk_reg(OFS_REAL, 8'h20, 1);
		chk_reg(OFS_IMAG, 8'h20, 1);
		wr(OFS_CONTROL, 8'h41);
		wait_cyc(1700);
		chk_reg(OFS_PHASE, 8'h40, 1);
		chk_reg(OFS_REAL, 8'h00, 1);
		chk_reg(OFS_IMAG, 8'h40, 1);
		wr(OFS_CONTROL, 8'h03);
		wait_cyc(1700);
		chk_reg(OFS_REAL, 8'h2d, 1);
		chk_reg(OFS_IMAG, 8'h2d, 1);
		alt = 1'b0;
	endtask

	task automatic t_freq;
		step = 3'h1;
		wr(OFS_CONTROL, 8'h23);
		wait_cyc(2450);
		chk_reg(OFS_QUALITY, 8'h40, 2);
		wr(OFS_CONTROL, 8'h03);
		wait_cyc(1700);
		chk_reg(OFS_QUALITY, 8'hfb, 4);
		// backwards rotation gives a negative offset
		step = 3'h7;
		wr(OFS_CONTROL, 8'h23);
		wait_cyc(2450);
		chk_reg(OFS_QUALITY, 8'hc0, 2);
		step = 3'h0;
	endtask

	task automatic t_align;
		int n;
		logic [7:0] d;
		base = 3'h0;
		wr(OFS_CONTROL, 8'h81);
		wait_cyc(1700);
		// first request lines the bench up with the period raster
		cf_req(n);
		wait_cyc(10);
		cf_req(n);
		check(8'(n < 2), 8'h00, 0);
		base = 3'h2;
		rd(OFS_CONTROL, d);
		check(d & 8'h1c, 8'h00, 0);
		check({7'h00, cf_change_apply}, 8'h00, 0);
		for (int k = 0; k < 8; k++) begin
			wait_cyc(k == 0 ? 49 : 99);
			rd(OFS_CONTROL, d);
			check({5'h00, d[4:2]}, 8'(k), 0);
		end
		wait_cyc(839);
		chk_reg(OFS_PHASE, 8'h00, 1);
		wait_cyc(19);
		chk_reg(OFS_PHASE, 8'h40, 1);
		// one phase jump early in the period costs two second differences
		chk_reg(OFS_QUALITY, 8'hbf, 4);
		chk_reg(OFS_REAL, 8'h00, 1);
		chk_reg(OFS_IMAG, 8'h3f, 1);
	endtask

	task automatic t_hold;
		run = 1'b0;
		wr(OFS_CONTROL, 8'h02);
		base = 3'h4;
		wait_cyc(1700);
		chk_reg(OFS_PHASE, 8'h40, 1);
		chk_reg(OFS_CONTROL, 8'h1e, 0);
		run = 1'b1;
		wr(OFS_CONTROL, 8'h03);
		chk_reg(OFS_CONTROL, 8'h03, 0);
		wait_cyc(1700);
		chk_reg(OFS_PHASE, 8'h80, 1);
	endtask

	// main sequence
	initial begin
		repeat (6) @(negedge ref_clk);
		rst = 1'b0;
		@(negedge ref_clk);
		t_reset;
		t_cf_now;
		t_const;
		t_avg;
		t_freq;
		t_align;
		t_hold;
		results;
	end

	// watchdog, well beyond the expected run of about 40000 cycles
	initial begin
		#800000;
		n_fail++;
		$display("BAD %0t timeout", $time);
		results;
	end
endmodule
